// >>> inc/crm_pkg.sv
// Shared constants and types for the register model and bus unit.
// Assumes a single 50 MHz core clock and an asynchronous active-low reset.
package crm_pkg;

	// Bus cycle timing in core clocks
	localparam int BUS_HALF_CYCLES = 4;
	localparam int BUS_CYCLE_CYCLES = 2 * BUS_HALF_CYCLES;
	localparam logic [2:0] BUS_HALF_PHASE = 3'(BUS_HALF_CYCLES);
	localparam logic [2:0] BUS_LAST_PHASE = 3'(BUS_CYCLE_CYCLES - 1);

	// Status word bit positions
	localparam int BIT_C = 0;
	localparam int BIT_Z = 1;
	localparam int BIT_I = 2;
	localparam int BIT_D = 3;
	localparam int BIT_X = 4;
	localparam int BIT_M = 5;
	localparam int BIT_V = 6;
	localparam int BIT_N = 7;
	localparam int BIT_BRK = 4;

	// Values after reset
	localparam logic [15:0] DP_RST = 16'h0000;
	localparam logic [15:0] SP_RST = 16'h0100;
	localparam logic [7:0] PBANK_RST = 8'h00;
	localparam logic [7:0] DBANK_RST = 8'h00;
	localparam logic [7:0] STATUS_RST = 8'h34;
	localparam logic EMU_RST = 1'b1;
	localparam logic [7:0] STACK_HIGH_EMU = 8'h01;
	localparam logic [7:0] ZERO_BANK = 8'h00;

	// Vector addresses, low byte first
	localparam logic [15:0] VEC_ABORT_EMU = 16'hfff8;
	localparam logic [15:0] VEC_ABORT_NAT = 16'hffe8;
	localparam logic [15:0] VEC_IRQ_EMU = 16'hfffe;
	localparam logic [15:0] VEC_IRQ_NAT = 16'hffee;

	// Step counts of the internal stack sequences
	localparam logic [2:0] INT_LAST_PUSH = 3'd3;
	localparam logic [2:0] INT_VEC_LO = 3'd4;
	localparam logic [2:0] INT_VEC_HI = 3'd5;
	localparam logic [2:0] RTI_LAST = 3'd3;

	typedef enum logic [1:0] {
		KIND_OPCODE,
		KIND_OPERAND,
		KIND_READ,
		KIND_WRITE
	} crm_kind_e;

	typedef enum logic [2:0] {
		MODE_ABS,
		MODE_ABS_X,
		MODE_ABS_Y,
		MODE_DIR,
		MODE_DIR_X,
		MODE_DIR_Y
	} crm_mode_e;

	typedef enum logic [3:0] {
		SEL_DIRECT,
		SEL_INDEX_X,
		SEL_INDEX_Y,
		SEL_ACC,
		SEL_ACC_SWAP,
		SEL_STATUS,
		SEL_PBANK,
		SEL_DBANK,
		SEL_PC,
		SEL_SP
	} crm_sel_e;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_WAIT,
		ST_INT,
		ST_RTI,
		ST_PHK
	} crm_state_e;

endpackage : crm_pkg

// >>> rtl/crm_sync2.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes each bit is sampled independently; multi-bit words must be stable.
`timescale 1ns/100ps
module crm_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] stable_reg;

	// First stage feeds only the second stage
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_reg <= RST_VAL;
			stable_reg <= RST_VAL;
		end
		else
		begin
			meta_reg <= async_in;
			stable_reg <= meta_reg;
		end
	end

	assign sync_out = stable_reg;

endmodule : crm_sync2

// >>> rtl/crm_core.sv
// Programmer register set, address formation and multiplexed bus unit.
// Assumes an instruction sequencer on core_clk drives the seq_ ports and
// external memory sits on the address, data/bank and strobe pins.
//
// How it works
// - Direct address is direct base plus 8-bit offset, bank zero.
// - Direct base clears to zero at reset.
// - Indexed modes add X or Y to absolute or direct base.
// - Native: index regs 16 bits, or 8 bits with high byte zero.
// - Eight-bit status: result flags plus program mode selects.
// - Emulation flag changes only by exchange with carry.
// - Emulation holds both width flags at one.
// - Emulation interrupt stacks the break indication in bit 4.
// - Program bank is the upper byte of every fetch address.
// - Program bank clears at reset; its push writes it to stack.
// - Program counter advances once per fetched instruction byte.
// - Stack pointer marks next free slot, bank zero, high one in emulation.
// - Abort suppresses register updates, then enters with opcode address.
// - Abort vector at fff8 in emulation, ffe8 native.
// - Any sampled abort low pulse registers an abort.
// - 24-bit address: sixteen address pins plus bank on data pins.
// - Bus enable floats address, strobe and data drivers.
// - Bank in first half, data in second; words take two cycles.
// - Emulation status pin follows the emulation flag.
// - Unmasked low interrupt request enters after instruction or wait.
// - Interrupt vector at fffe in emulation, ffee native.
// - Entry pushes bank, counter high, low, status; return pulls them.
// - Accumulator 16 bits, or 8 bits keeping the high byte for swap.
// - Data bank is upper byte of absolute data addresses, cleared at reset.
`timescale 1ns/100ps
module crm_core
	import crm_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic seq_req_valid,
	input wire crm_kind_e seq_req_kind,
	input wire crm_mode_e seq_req_mode,
	input wire logic [15:0] seq_req_base,
	input wire logic [7:0] seq_req_wdata,
	output logic seq_req_ready,
	output logic seq_rsp_valid,
	output logic [7:0] seq_rsp_data,
	input wire logic seq_wr_en,
	input wire crm_sel_e seq_wr_sel,
	input wire logic [15:0] seq_wr_data,
	input wire logic seq_xce,
	input wire logic seq_phk,
	input wire logic seq_rti,
	input wire logic seq_wai,
	input wire logic seq_instr_end,
	input wire logic seq_break,
	output logic [15:0] direct_page_base,
	output logic [15:0] index_x,
	output logic [15:0] index_y,
	output logic [15:0] accum,
	output logic [7:0] status_word,
	output logic [7:0] program_bank,
	output logic [7:0] data_bank,
	output logic [15:0] program_counter,
	output logic [15:0] stack_pointer,
	output logic emulation_status,
	output logic [15:0] addr_out,
	output logic addr_oe_n,
	output logic [7:0] data_out,
	output logic data_oe_n,
	input wire logic [7:0] data_in,
	output logic read_write_strobe,
	output logic rw_oe_n,
	output logic phase_two_clock,
	input wire logic bus_enable,
	input wire logic abort_request,
	input wire logic irq_request
);
	logic be_s;
	logic abort_s;
	logic irq_s;
	logic [7:0] din_s;

	crm_sync2 #(.W(11), .RST_VAL({1'b0, 1'b1, 1'b1, 8'h00})) u_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.async_in({bus_enable, abort_request, irq_request, data_in}),
		.sync_out({be_s, abort_s, irq_s, din_s})
	);

	logic [15:0] dp_reg, dp_next, x_reg, x_next, y_reg, y_next;
	logic [15:0] acc_reg, acc_next, pc_reg, pc_next, sp_reg, sp_next;
	logic [15:0] opaddr_reg, opaddr_next, retpc_reg, retpc_next;
	logic [15:0] vec_reg, vec_next;
	logic [7:0] status_reg, status_next, pbank_reg, pbank_next;
	logic [7:0] dbank_reg, dbank_next;
	logic emu_reg, emu_next, brk_reg, brk_next;
	logic abort_pend_reg, abort_pend_next, abort_prev_reg, abort_prev_next;
	logic ready_reg, ready_next;
	crm_state_e state_reg, state_next;
	logic [2:0] step_reg, step_next;

	logic bus_busy_reg, bus_busy_next, cur_rw_reg, cur_rw_next;
	logic cur_fetch_reg, cur_fetch_next, cur_seq_reg, cur_seq_next;
	logic [2:0] phase_reg, phase_next;
	logic [23:0] cur_addr_reg, cur_addr_next;
	logic [7:0] cur_wdata_reg, cur_wdata_next;
	logic [15:0] addr_out_reg, addr_out_next;
	logic [7:0] data_out_reg, data_out_next, rsp_data_reg, rsp_data_next;
	logic addr_oe_n_reg, addr_oe_n_next, data_oe_n_reg, data_oe_n_next;
	logic rw_reg, rw_next, rw_oe_n_reg, rw_oe_n_next;
	logic phase_two_clock_reg, phase_two_clock_next, rsp_valid_reg, rsp_valid_next;

	logic bus_done, int_done, first_half;
	logic st_go, st_rw, st_fetch, st_seq;
	logic [23:0] st_addr;
	logic [7:0] st_wdata, push_status;
	logic [15:0] idx_val, sp_dec, sp_inc;
	logic enter_abort, enter_irq;

	assign bus_done = bus_busy_reg && (phase_reg == BUS_LAST_PHASE);
	assign int_done = bus_done && !cur_seq_reg;

	// Register set and sequencing
	always_comb
	begin
		dp_next = dp_reg;
		x_next = x_reg;
		y_next = y_reg;
		acc_next = acc_reg;
		status_next = status_reg;
		emu_next = emu_reg;
		pbank_next = pbank_reg;
		dbank_next = dbank_reg;
		pc_next = pc_reg;
		sp_next = sp_reg;
		opaddr_next = opaddr_reg;
		retpc_next = retpc_reg;
		vec_next = vec_reg;
		brk_next = brk_reg;
		state_next = state_reg;
		step_next = step_reg;
		abort_pend_next = abort_pend_reg;
		abort_prev_next = abort_s;
		st_go = 1'b0;
		st_addr = '0;
		st_rw = 1'b1;
		st_wdata = '0;
		st_fetch = 1'b0;
		st_seq = 1'b0;
		enter_abort = 1'b0;
		enter_irq = 1'b0;
		if (seq_req_mode == MODE_ABS_X || seq_req_mode == MODE_DIR_X)
			idx_val = x_reg;
		else if (seq_req_mode == MODE_ABS_Y || seq_req_mode == MODE_DIR_Y)
			idx_val = y_reg;
		else
			idx_val = 16'h0000;
		// Emulation wraps the stack inside page one
		sp_dec = emu_reg ? {STACK_HIGH_EMU, sp_reg[7:0] - 8'h01}
			: sp_reg - 16'h0001;
		sp_inc = emu_reg ? {STACK_HIGH_EMU, sp_reg[7:0] + 8'h01}
			: sp_reg + 16'h0001;
		push_status = emu_reg
			? {status_reg[7:5], brk_reg, status_reg[3:0]} : status_reg;
		if (bus_done && cur_fetch_reg)
			pc_next = pc_reg + 16'h0001;
		unique case (state_reg)
			ST_RUN:
			begin
				if (!bus_busy_reg && seq_req_valid)
				begin
					st_go = 1'b1;
					st_seq = 1'b1;
					if (seq_req_kind == KIND_OPCODE || seq_req_kind == KIND_OPERAND)
					begin
						st_addr = {pbank_reg, pc_reg};
						st_fetch = 1'b1;
						if (seq_req_kind == KIND_OPCODE)
							opaddr_next = pc_reg;
					end
					else
					begin
						st_rw = (seq_req_kind != KIND_WRITE);
						st_wdata = seq_req_wdata;
						if (seq_req_mode == MODE_ABS || seq_req_mode == MODE_ABS_X
							|| seq_req_mode == MODE_ABS_Y)
							st_addr = {dbank_reg, seq_req_base}
								+ {8'h00, idx_val};
						else
							st_addr = {ZERO_BANK, dp_reg
								+ {8'h00, seq_req_base[7:0]} + idx_val};
					end
				end
				// No register write or exchange of the aborted instruction may land
				if (!abort_pend_reg && seq_wr_en)
				begin
					case (seq_wr_sel)
						SEL_DIRECT: dp_next = seq_wr_data;
						SEL_INDEX_X: x_next = seq_wr_data;
						SEL_INDEX_Y: y_next = seq_wr_data;
						SEL_ACC:
							if (status_reg[BIT_M])
								acc_next[7:0] = seq_wr_data[7:0];
							else
								acc_next = seq_wr_data;
						SEL_ACC_SWAP: acc_next = {acc_reg[7:0], acc_reg[15:8]};
						SEL_STATUS: status_next = seq_wr_data[7:0];
						SEL_PBANK: pbank_next = seq_wr_data[7:0];
						SEL_DBANK: dbank_next = seq_wr_data[7:0];
						SEL_PC: pc_next = seq_wr_data;
						SEL_SP: sp_next = seq_wr_data;
						default: dp_next = dp_reg;
					endcase
				end
				if (!abort_pend_reg && seq_xce)
				begin
					emu_next = status_reg[BIT_C];
					status_next[BIT_C] = emu_reg;
				end
				if (seq_phk)
				begin
					state_next = ST_PHK;
					step_next = 3'd0;
				end
				else if (seq_rti)
				begin
					state_next = ST_RTI;
					step_next = 3'd0;
				end
				else if (seq_wai)
					state_next = ST_WAIT;
				else if (seq_instr_end)
				begin
					if (abort_pend_reg)
						enter_abort = 1'b1;
					else if (!irq_s && !status_reg[BIT_I])
						enter_irq = 1'b1;
				end
			end
			ST_WAIT:
			begin
				if (abort_pend_reg)
					enter_abort = 1'b1;
				else if (!irq_s)
				begin
					// Masked request only releases the wait
					if (status_reg[BIT_I])
						state_next = ST_RUN;
					else
						enter_irq = 1'b1;
				end
			end
			ST_INT:
			begin
				if (!bus_busy_reg)
				begin
					st_go = 1'b1;
					if (step_reg <= INT_LAST_PUSH)
					begin
						st_rw = 1'b0;
						st_addr = {ZERO_BANK, sp_reg};
						sp_next = sp_dec;
						case (step_reg)
							3'd0: st_wdata = pbank_reg;
							3'd1: st_wdata = retpc_reg[15:8];
							3'd2: st_wdata = retpc_reg[7:0];
							default: st_wdata = push_status;
						endcase
					end
					else
						st_addr = {ZERO_BANK, vec_reg
							+ {13'h0000, step_reg - INT_VEC_LO}};
				end
				if (int_done)
				begin
					step_next = step_reg + 3'd1;
					if (step_reg == INT_VEC_LO)
						pc_next[7:0] = din_s;
					if (step_reg == INT_VEC_HI)
					begin
						pc_next[15:8] = din_s;
						pbank_next = ZERO_BANK;
						status_next[BIT_I] = 1'b1;
						state_next = ST_RUN;
					end
				end
			end
			ST_RTI:
			begin
				if (!bus_busy_reg)
				begin
					st_go = 1'b1;
					st_addr = {ZERO_BANK, sp_inc};
					sp_next = sp_inc;
				end
				if (int_done)
				begin
					step_next = step_reg + 3'd1;
					case (step_reg)
						3'd0: status_next = din_s;
						3'd1: pc_next[7:0] = din_s;
						3'd2: pc_next[15:8] = din_s;
						default: pbank_next = din_s;
					endcase
					if (step_reg == RTI_LAST)
						state_next = ST_RUN;
				end
			end
			ST_PHK:
			begin
				if (!bus_busy_reg && step_reg == 3'd0)
				begin
					st_go = 1'b1;
					st_rw = 1'b0;
					st_addr = {ZERO_BANK, sp_reg};
					st_wdata = pbank_reg;
					sp_next = sp_dec;
					step_next = 3'd1;
				end
				if (int_done)
					state_next = ST_RUN;
			end
		endcase
		if (enter_abort || enter_irq)
		begin
			state_next = ST_INT;
			step_next = 3'd0;
			retpc_next = enter_abort ? opaddr_reg : pc_reg;
			brk_next = seq_break;
			if (enter_abort)
				vec_next = emu_reg ? VEC_ABORT_EMU : VEC_ABORT_NAT;
			else
				vec_next = emu_reg ? VEC_IRQ_EMU : VEC_IRQ_NAT;
			abort_pend_next = 1'b0;
		end
		// A new abort in the clearing cycle is kept
		if (abort_prev_reg && !abort_s)
			abort_pend_next = 1'b1;
		if (emu_next)
		begin
			status_next[BIT_M] = 1'b1;
			status_next[BIT_X] = 1'b1;
			sp_next[15:8] = STACK_HIGH_EMU;
		end
		if (status_next[BIT_X])
		begin
			x_next[15:8] = 8'h00;
			y_next[15:8] = 8'h00;
		end
		ready_next = (state_next == ST_RUN) && !st_go
			&& !(bus_busy_reg && !bus_done);
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			dp_reg <= DP_RST;
			x_reg <= '0;
			y_reg <= '0;
			acc_reg <= '0;
			status_reg <= STATUS_RST;
			emu_reg <= EMU_RST;
			pbank_reg <= PBANK_RST;
			dbank_reg <= DBANK_RST;
			pc_reg <= '0;
			sp_reg <= SP_RST;
			opaddr_reg <= '0;
			retpc_reg <= '0;
			vec_reg <= '0;
			brk_reg <= 1'b0;
			state_reg <= ST_RUN;
			step_reg <= '0;
			abort_pend_reg <= 1'b0;
			abort_prev_reg <= 1'b1;
			ready_reg <= 1'b0;
		end
		else
		begin
			dp_reg <= dp_next;
			x_reg <= x_next;
			y_reg <= y_next;
			acc_reg <= acc_next;
			status_reg <= status_next;
			emu_reg <= emu_next;
			pbank_reg <= pbank_next;
			dbank_reg <= dbank_next;
			pc_reg <= pc_next;
			sp_reg <= sp_next;
			opaddr_reg <= opaddr_next;
			retpc_reg <= retpc_next;
			vec_reg <= vec_next;
			brk_reg <= brk_next;
			state_reg <= state_next;
			step_reg <= step_next;
			abort_pend_reg <= abort_pend_next;
			abort_prev_reg <= abort_prev_next;
			ready_reg <= ready_next;
		end
	end

	// Bus cycle engine: bank in the low half, data in the high half
	always_comb
	begin
		bus_busy_next = bus_busy_reg;
		phase_next = phase_reg;
		cur_addr_next = cur_addr_reg;
		cur_rw_next = cur_rw_reg;
		cur_wdata_next = cur_wdata_reg;
		cur_fetch_next = cur_fetch_reg;
		cur_seq_next = cur_seq_reg;
		if (st_go)
		begin
			bus_busy_next = 1'b1;
			phase_next = 3'd0;
			cur_addr_next = st_addr;
			cur_rw_next = st_rw;
			cur_wdata_next = st_wdata;
			cur_fetch_next = st_fetch;
			cur_seq_next = st_seq;
		end
		else if (bus_done)
			bus_busy_next = 1'b0;
		else if (bus_busy_reg)
			phase_next = phase_reg + 3'd1;
		first_half = phase_next < BUS_HALF_PHASE;
		phase_two_clock_next = bus_busy_next && !first_half;
		addr_out_next = cur_addr_next[15:0];
		data_out_next = first_half ? cur_addr_next[23:16]
			: cur_wdata_next;
		// Bus enable is sampled, so release lags the pin by three clocks
		data_oe_n_next = !(be_s && bus_busy_next
			&& (first_half || !cur_rw_next));
		addr_oe_n_next = !be_s;
		rw_oe_n_next = !be_s;
		rw_next = !bus_busy_next || cur_rw_next;
		rsp_valid_next = bus_done && cur_seq_reg;
		rsp_data_next = bus_done ? din_s : rsp_data_reg;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bus_busy_reg <= 1'b0;
			phase_reg <= '0;
			cur_addr_reg <= '0;
			cur_rw_reg <= 1'b1;
			cur_wdata_reg <= '0;
			cur_fetch_reg <= 1'b0;
			cur_seq_reg <= 1'b0;
			phase_two_clock_reg <= 1'b0;
			addr_out_reg <= '0;
			data_out_reg <= '0;
			data_oe_n_reg <= 1'b1;
			addr_oe_n_reg <= 1'b1;
			rw_oe_n_reg <= 1'b1;
			rw_reg <= 1'b1;
			rsp_valid_reg <= 1'b0;
			rsp_data_reg <= '0;
		end
		else
		begin
			bus_busy_reg <= bus_busy_next;
			phase_reg <= phase_next;
			cur_addr_reg <= cur_addr_next;
			cur_rw_reg <= cur_rw_next;
			cur_wdata_reg <= cur_wdata_next;
			cur_fetch_reg <= cur_fetch_next;
			cur_seq_reg <= cur_seq_next;
			phase_two_clock_reg <= phase_two_clock_next;
			addr_out_reg <= addr_out_next;
			data_out_reg <= data_out_next;
			data_oe_n_reg <= data_oe_n_next;
			addr_oe_n_reg <= addr_oe_n_next;
			rw_oe_n_reg <= rw_oe_n_next;
			rw_reg <= rw_next;
			rsp_valid_reg <= rsp_valid_next;
			rsp_data_reg <= rsp_data_next;
		end
	end

	assign seq_req_ready = ready_reg;
	assign seq_rsp_valid = rsp_valid_reg;
	assign seq_rsp_data = rsp_data_reg;
	assign direct_page_base = dp_reg;
	assign index_x = x_reg;
	assign index_y = y_reg;
	assign accum = acc_reg;
	assign status_word = status_reg;
	assign program_bank = pbank_reg;
	assign data_bank = dbank_reg;
	assign program_counter = pc_reg;
	assign stack_pointer = sp_reg;
	assign emulation_status = emu_reg;
	assign addr_out = addr_out_reg;
	assign addr_oe_n = addr_oe_n_reg;
	assign data_out = data_out_reg;
	assign data_oe_n = data_oe_n_reg;
	assign read_write_strobe = rw_reg;
	assign rw_oe_n = rw_oe_n_reg;
	assign phase_two_clock = phase_two_clock_reg;

endmodule : crm_core

// >>> tb/crm_core_properties.sv
// Concurrent checks on the ports of the register model and bus unit.
// Assumes one clock domain; bound onto every crm_core instance.
`timescale 1ns/100ps
module crm_core_chk
	import crm_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic seq_req_valid,
	input wire crm_kind_e seq_req_kind,
	input wire logic seq_req_ready,
	input wire logic seq_rsp_valid,
	input wire logic seq_xce,
	input wire logic [15:0] index_x,
	input wire logic [15:0] index_y,
	input wire logic [7:0] status_word,
	input wire logic [7:0] program_bank,
	input wire logic [15:0] program_counter,
	input wire logic [15:0] stack_pointer,
	input wire logic emulation_status,
	input wire logic addr_oe_n,
	input wire logic [7:0] data_out,
	input wire logic data_oe_n,
	input wire logic read_write_strobe,
	input wire logic rw_oe_n,
	input wire logic phase_two_clock,
	input wire logic bus_enable
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	wire take = seq_req_valid && seq_req_ready;
	a_emu_width_flags: assert property (
		emulation_status |-> status_word[BIT_M] && status_word[BIT_X])
		else $error("width flags clear in emulation");
	a_emu_stack_high: assert property (
		emulation_status |-> stack_pointer[15:8] == STACK_HIGH_EMU)
		else $error("stack high byte not one in emulation");
	a_index_high_zero: assert property (
		status_word[BIT_X] |-> index_x[15:8] == 8'h00 && index_y[15:8] == 8'h00)
		else $error("index high byte not zero");
	a_float_on_disable: assert property (
		!bus_enable [*5] |-> addr_oe_n && data_oe_n && rw_oe_n)
		else $error("pins driven with bus disabled");
	a_cycle_answer: assert property (
		take |=> !seq_req_ready [*8] ##1 seq_rsp_valid)
		else $error("bus cycle answer misplaced");
	a_fetch_bank: assert property (
		take && seq_req_kind == KIND_OPCODE |=>
			data_oe_n || data_out == program_bank)
		else $error("fetch bank byte wrong");
	a_read_released: assert property (
		phase_two_clock && read_write_strobe |-> data_oe_n)
		else $error("data pins driven in read data half");
	a_fetch_pc_step: assert property (
		take && seq_req_kind == KIND_OPCODE |-> ##9 (seq_rsp_valid &&
			program_counter == $past(program_counter, 9) + 16'h1))
		else $error("counter not advanced by fetch");
	a_emu_exchange: assert property (
		$changed(emulation_status) |-> $past(seq_xce) &&
			status_word[BIT_C] == $past(emulation_status))
		else $error("emulation flag changed without exchange");
endmodule : crm_core_chk

bind crm_core crm_core_chk u_crm_core_chk (.core_clk, .rstn,
	.seq_req_valid, .seq_req_kind, .seq_req_ready, .seq_rsp_valid,
	.seq_xce, .index_x, .index_y, .status_word, .program_bank,
	.program_counter, .stack_pointer, .emulation_status, .addr_oe_n,
	.data_out, .data_oe_n, .read_write_strobe, .rw_oe_n,
	.phase_two_clock, .bus_enable);

// >>> tb/crm_mem_model.sv
// External memory on the multiplexed address, bank and data pins.
// Assumes bank byte in the first half, data in the second half.
`timescale 1ns/100ps
module crm_mem_model (
	input wire logic core_clk,
	input wire logic [15:0] addr_out,
	input wire logic addr_oe_n,
	input wire logic [7:0] data_out,
	input wire logic data_oe_n,
	input wire logic read_write_strobe,
	input wire logic phase_two_clock,
	output logic [7:0] data_in
);
	logic [7:0] mem [logic [23:0]];
	logic [7:0] bank = 8'h00;
	logic [23:0] ea;
	assign ea = {bank, addr_out};
	initial data_in = 8'h00;
	always @(posedge core_clk)
	begin
		if (!phase_two_clock && !data_oe_n)
			bank <= data_out;
		if (phase_two_clock && !read_write_strobe && !data_oe_n && !addr_oe_n)
			mem[ea] = data_out;
		if (phase_two_clock && read_write_strobe && !addr_oe_n)
			data_in <= mem.exists(ea) ? mem[ea] : 8'h00;
		else
			data_in <= ~data_in; // Idle bus inverts every bit of the last byte each clock
	end
endmodule : crm_mem_model

// >>> tb/crm_core_bench.sv
// Self-checking bench for crm_core with an external memory model.
// Assumes 50 MHz core_clk; inputs change on the falling edge.
`timescale 1ns/100ps
module crm_core_bench
	import crm_pkg::*;
;
	logic core_clk, rstn, seq_req_valid, seq_wr_en, seq_xce, seq_phk;
	logic seq_rti, seq_wai, seq_instr_end, seq_break, bus_enable;
	logic abort_request, irq_request, seq_req_ready, seq_rsp_valid;
	logic emulation_status, addr_oe_n, data_oe_n, read_write_strobe;
	logic rw_oe_n, phase_two_clock;
	crm_kind_e seq_req_kind;
	crm_mode_e seq_req_mode;
	crm_sel_e seq_wr_sel;
	logic [15:0] seq_req_base, seq_wr_data, direct_page_base, index_x;
	logic [15:0] index_y, accum, program_counter, stack_pointer, addr_out;
	logic [7:0] seq_req_wdata, data_in, seq_rsp_data, status_word, rd;
	logic [7:0] program_bank, data_bank, data_out;
	int fail_count, checks, cycles;

	crm_core u_crm_core (.*);
	crm_mem_model u_mem (.*);

	always #10 core_clk = ~core_clk;

	task automatic check(input logic [23:0] seen, exp);
		checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("checks %0d failures %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	task automatic wait_ready(input logic lvl);
		int n;
		n = 0;
		while (seq_req_ready !== lvl && n < 300)
		begin
			@(negedge core_clk);
			n++;
		end
		check(16'(n < 300), 16'h1);
	endtask : wait_ready

	task automatic bus(input crm_kind_e k, crm_mode_e m,
		logic [15:0] b, logic [7:0] w);
		@(negedge core_clk);
		seq_req_valid = 1'b1;
		seq_req_kind = k;
		seq_req_mode = m;
		seq_req_base = b;
		seq_req_wdata = w;
		do @(posedge core_clk); while (seq_req_ready !== 1'b1);
		@(negedge core_clk);
		seq_req_valid = 1'b0;
		wait_ready(1'b1);
		rd = seq_rsp_data;
	endtask : bus

	task automatic wr(input crm_sel_e s, input logic [15:0] d);
		@(negedge core_clk);
		seq_wr_en = 1'b1;
		seq_wr_sel = s;
		seq_wr_data = d;
		@(negedge core_clk);
		seq_wr_en = 1'b0;
	endtask : wr

	task automatic pulse(input int c);
		@(negedge core_clk);
		seq_xce = (c == 0);
		seq_phk = (c == 1);
		seq_rti = (c == 2);
		seq_instr_end = (c == 3);
		seq_wai = (c == 4);
		@(negedge core_clk);
		{seq_xce, seq_phk, seq_rti, seq_instr_end, seq_wai} = 5'h00;
		if (c != 0)
		begin
			wait_ready(1'b0);
			wait_ready(1'b1);
		end
	endtask : pulse

	task automatic enter(input logic abt, input logic [15:0] vec);
		u_mem.mem[{8'h00, vec}] = 8'h11;
		u_mem.mem[{8'h00, vec + 16'h1}] = vec[7:0];
		abort_request = !abt;
		irq_request = abt;
		repeat (4) @(negedge core_clk);
		abort_request = 1'b1;
		if (abt)
			wr(SEL_INDEX_Y, 16'h0077);
		pulse(3);
		irq_request = 1'b1;
		check(program_counter, {vec[7:0], 8'h11});
		check(index_y, 16'h0010);
		check(status_word[BIT_I], 1'b1);
	endtask : enter

	initial
	begin
		{core_clk, rstn, seq_req_valid, seq_wr_en, seq_xce} = 5'h00;
		{seq_phk, seq_rti, seq_wai, seq_instr_end, seq_break} = 5'h00;
		{bus_enable, abort_request, irq_request} = 3'h7;
		{seq_req_base, seq_wr_data, seq_req_wdata} = 40'h0;
		seq_req_kind = KIND_OPCODE;
		seq_req_mode = MODE_ABS;
		seq_wr_sel = SEL_DIRECT;
		repeat (3) @(negedge core_clk);
		rstn = 1'b1;
		@(negedge core_clk);
		check(direct_page_base, 16'h0000);
		check({program_bank, data_bank}, 16'h0000);
		check(stack_pointer, 16'h0100);
		check(status_word, 8'h34);
		check(emulation_status, 1'b1);
		wr(SEL_STATUS, 16'h0000);
		check(status_word, 8'h30);
		pulse(0);
		check({emulation_status, status_word}, 9'h031);
		wr(SEL_STATUS, 16'h0000);
		wr(SEL_INDEX_X, 16'h1234);
		check(index_x, 16'h1234);
		wr(SEL_STATUS, 16'h0010);
		check(index_x, 16'h0034);
		wr(SEL_STATUS, 16'h0000);
		wr(SEL_ACC, 16'h1234);
		wr(SEL_ACC_SWAP, 16'h0000);
		check(accum, 16'h3412);
		wr(SEL_STATUS, 16'h0020);
		wr(SEL_ACC, 16'h00ff);
		check(accum, 16'h34ff);
		wr(SEL_STATUS, 16'h0000);
		wr(SEL_DIRECT, 16'h1200);
		wr(SEL_DBANK, 16'h0003);
		wr(SEL_INDEX_X, 16'h0005);
		wr(SEL_INDEX_Y, 16'h0010);
		u_mem.mem[24'h001280] = 8'h5a;
		u_mem.mem[24'h001285] = 8'h6b;
		u_mem.mem[24'h032010] = 8'h7c;
		bus(KIND_READ, MODE_DIR, 16'hff80, 8'h00);
		check(rd, 8'h5a);
		bus(KIND_READ, MODE_DIR_X, 16'h0080, 8'h00);
		check(rd, 8'h6b);
		bus(KIND_READ, MODE_ABS_Y, 16'h2000, 8'h00);
		check(rd, 8'h7c);
		bus(KIND_READ, MODE_ABS_X, 16'h200b, 8'h00);
		check(rd, 8'h7c);
		bus(KIND_READ, MODE_DIR_Y, 16'h0070, 8'h00);
		check(rd, 8'h5a);
		bus(KIND_WRITE, MODE_ABS, 16'h4000, 8'ha5);
		check(u_mem.mem[24'h034000], 8'ha5);
		wr(SEL_PBANK, 16'h0002);
		wr(SEL_PC, 16'h1000);
		u_mem.mem[24'h021000] = 8'hea;
		u_mem.mem[24'h021001] = 8'h42;
		bus(KIND_OPCODE, MODE_ABS, 16'h0000, 8'h00);
		check(rd, 8'hea);
		bus(KIND_OPERAND, MODE_ABS, 16'h0000, 8'h00);
		check({rd, program_counter}, 24'h421002);
		wr(SEL_SP, 16'h01ff);
		pulse(1);
		check(u_mem.mem[24'h0001ff], 8'h02);
		check(stack_pointer, 16'h01fe);
		enter(1'b0, VEC_IRQ_NAT);
		check(stack_pointer, 16'h01fa);
		check(u_mem.mem[24'h0001fe], 8'h02);
		check(u_mem.mem[24'h0001fd], 8'h10);
		check(u_mem.mem[24'h0001fc], 8'h02);
		check(u_mem.mem[24'h0001fb], 8'h00);
		pulse(2);
		check({program_bank, program_counter}, 24'h021002);
		check(stack_pointer, 16'h01fe);
		enter(1'b1, VEC_ABORT_NAT);
		check(u_mem.mem[24'h0001fc], 8'h00);
		wr(SEL_SP, 16'h02fe);
		wr(SEL_STATUS, 16'h0001);
		pulse(0);
		check(stack_pointer, 16'h01fe);
		check({emulation_status, status_word}, 9'h130);
		enter(1'b0, VEC_IRQ_EMU);
		check(u_mem.mem[24'h0001fb], 8'h20);
		enter(1'b1, VEC_ABORT_EMU);
		irq_request = 1'b0;
		repeat (3) @(negedge core_clk);
		pulse(4);
		irq_request = 1'b1;
		check(program_counter, 16'hf811);
		check(stack_pointer, 16'h01f6);
		bus_enable = 1'b0;
		repeat (6) @(negedge core_clk);
		check({addr_oe_n, data_oe_n, rw_oe_n}, 3'h7);
		bus_enable = 1'b1;
		wrap_up();
	end

	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles > 5000)
		begin
			fail_count++;
			wrap_up();
		end
	end
endmodule : crm_core_bench
